// ---- common/cmd_status_pkg.sv ----
// Constants and types shared by the common command and status unit
// Overview of operation
// RQ1 - Clear-status zeroes status byte and event register, drops pending work, keeps settings
// RQ2 - Event-enable command loads its mask from decimal sum; only enabled events raise summary
// RQ3 - Event-enable query returns the mask as decimal sum plus terminator
// RQ4 - Each event bit latches on its event; repeats while set change nothing
// RQ5 - Latched event bits stay until event query reads them or clear-status runs
// RQ6 - Identity query returns maker, model, serial and main/converter firmware fields
// RQ7 - Operation-complete command sets event bit 0 when started work finishes
// RQ8 - Operation-complete query holds off until work finishes, then replies 1 plus terminator
// RQ9 - Operation-complete query neither reads nor changes event bit 0
// RQ10 - Reset command restores power-up settings, not factory defaults
// RQ11 - Service-enable command loads mask; masked-in summaries alone raise bit 6 request
// RQ12 - Service-enable query returns the mask as decimal sum plus terminator
// RQ13 - Status-byte query runs like any command and leaves bit 6 uncleared
// RQ14 - Trigger command starts the trigger using the previously set trigger setup
// RQ15 - Self-test query returns stored power-up result: 0 no errors, 1 errors
// RQ16 - Queries need the trailing question mark; without it nothing is answered
// RQ17 - Misspelled commands and queries are ignored without action or reply
// RQ18 - Terminator code: 0 CR LF, 1 LF CR, 2 LF only, 3 none
// RQ19 - Wait-to-continue holds later commands until started work has completed
// RQ20 - Event summary bit is OR of event bits ANDed with enables, every clock
// RQ21 - Host appends terminator and sends each whole message before awaiting reply
package cmd_status_pkg;
    localparam int ADDR_W = 8;
    localparam int MAX_ID_LEN = 32;

    localparam logic [ADDR_W-1:0] ADDR_RX_DATA = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_TX_DATA = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_STB     = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_ESR     = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_ENABLES = 8'h18;

    localparam logic [1:0] TERM_RESET = 2'h0;
    localparam logic [1:0] TERM_CRLF  = 2'h0;
    localparam logic [1:0] TERM_LFCR  = 2'h1;
    localparam logic [1:0] TERM_LF    = 2'h2;
    localparam logic [1:0] TERM_NONE  = 2'h3;

    localparam int BIT_OPC = 0;
    localparam int BIT_ESB = 5;
    localparam int BIT_MSS = 6;
    localparam logic [7:0] MSS_MASK_OUT = 8'hbf;

    localparam logic [7:0] CH_CR    = 8'h0d;
    localparam logic [7:0] CH_LF    = 8'h0a;
    localparam logic [7:0] CH_SEMI  = 8'h3b;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_COMMA = 8'h2c;
    localparam logic [7:0] CH_ZERO  = 8'h30;
    localparam logic [7:0] CH_ONE   = 8'h31;
    localparam logic [7:0] CH_NINE  = 8'h39;
    localparam logic [7:0] CH_LOW_A = 8'h61;
    localparam logic [7:0] CH_LOW_Z = 8'h7a;
    localparam logic [7:0] CASE_GAP = 8'h20;

    localparam logic [39:0] MN_CLS  = 40'h002a434c53;
    localparam logic [39:0] MN_ESE  = 40'h002a455345;
    localparam logic [39:0] MN_ESEQ = 40'h2a4553453f;
    localparam logic [39:0] MN_ESRQ = 40'h2a4553523f;
    localparam logic [39:0] MN_IDNQ = 40'h2a49444e3f;
    localparam logic [39:0] MN_OPC  = 40'h002a4f5043;
    localparam logic [39:0] MN_OPCQ = 40'h2a4f50433f;
    localparam logic [39:0] MN_RST  = 40'h002a525354;
    localparam logic [39:0] MN_SRE  = 40'h002a535245;
    localparam logic [39:0] MN_SREQ = 40'h2a5352453f;
    localparam logic [39:0] MN_STBQ = 40'h2a5354423f;
    localparam logic [39:0] MN_TRG  = 40'h002a545247;
    localparam logic [39:0] MN_TSTQ = 40'h2a5453543f;
    localparam logic [39:0] MN_WAI  = 40'h002a574149;

    localparam logic [9:0] ACC_LIMIT = 10'h064;
    localparam logic [9:0] ACC_SAT   = 10'h3ff;
    localparam logic [9:0] ACC_TEN   = 10'h00a;

    typedef enum logic [1:0] {
        ST_MNEM  = 2'b00,
        ST_PARAM = 2'b01,
        ST_WAIT  = 2'b11,
        ST_REPLY = 2'b10
    } parse_state_type;

    typedef enum logic [1:0] {
        RK_NUM = 2'b00,
        RK_ONE = 2'b01,
        RK_IDN = 2'b11
    } reply_kind_type;
endpackage

// ---- hdl/common_command_status_unit.sv ----
// Common command interpreter with status byte and event registers, APB slave
`timescale 1ns/1ps
module common_command_status_unit #(
    parameter int                  ID_LEN   = 28,
    // Identity text; the value is arbitrary
    parameter logic [8*ID_LEN-1:0] IDN_TEXT = "MFGR,MODEL-A,0000001,1.0/1.0"
) (
    input  wire logic                               pclk,
    input  wire logic                               presetn,
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [cmd_status_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                        pwdata,
    output logic      [31:0]                        prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    input  wire logic                               ops_busy,
    input  wire logic [7:1]                         event_in,
    input  wire logic [7:0]                         summary_in,
    input  wire logic                               selftest_fail,
    output logic                                    service_request,
    output logic                                    trigger_start,
    output logic                                    power_up_reset,
    output logic                                    clear_pending
);
    import cmd_status_pkg::*;

    generate
        if (ID_LEN < 1 || ID_LEN > MAX_ID_LEN) begin : g_bad_len
            $error("ID_LEN out of range");
        end
    endgenerate

    parse_state_type state;
    parse_state_type next_state;
    reply_kind_type  reply_kind;
    reply_kind_type  next_kind;

    logic [39:0] mnem;
    logic [39:0] next_mnem;
    logic        mnem_bad;
    logic        next_bad;
    logic [9:0]  acc;
    logic [9:0]  next_acc;
    logic        have_param;
    logic        next_have;
    logic [7:0]  esr;
    logic [7:0]  ese;
    logic [7:0]  sre;
    logic        opc_pending;
    logic [1:0]  term_sel;
    logic [7:0]  reply_value;
    logic [7:0]  next_value;
    logic [5:0]  reply_idx;
    logic        tst_taken;
    logic        tst_result;

    // APB decode
    wire setup   = psel & ~penable;
    wire access  = psel & penable;
    wire hit_rx  = paddr == ADDR_RX_DATA;
    wire hit_tx  = paddr == ADDR_TX_DATA;
    wire hit_st  = paddr == ADDR_STATUS;
    wire hit_ctl = paddr == ADDR_CONTROL;
    wire hit_stb = paddr == ADDR_STB;
    wire hit_esr = paddr == ADDR_ESR;
    wire hit_en  = paddr == ADDR_ENABLES;
    wire mapped  = hit_rx | hit_tx | hit_st | hit_ctl | hit_stb | hit_esr | hit_en;
    wire wr_rx   = access & pwrite & hit_rx;
    wire wr_ctl  = access & pwrite & hit_ctl;
    wire rd_tx   = access & ~pwrite & hit_tx;

    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // Incoming character, folded to upper case
    wire       rx_ready = (state == ST_MNEM) | (state == ST_PARAM);
    wire       take     = wr_rx & rx_ready;
    wire [7:0] rx_raw   = pwdata[7:0];
    wire       is_lower = (rx_raw >= CH_LOW_A) & (rx_raw <= CH_LOW_Z);
    wire [7:0] rx_char  = is_lower ? rx_raw - CASE_GAP : rx_raw;
    wire       is_sep   = (rx_char == CH_SEMI) | (rx_char == CH_CR) | (rx_char == CH_LF);
    wire       is_space = rx_char == CH_SPACE;
    wire       is_digit = (rx_char >= CH_ZERO) & (rx_char <= CH_NINE);
    wire [9:0] digit    = {6'h00, rx_char[3:0]};
    wire [9:0] acc_step = (acc < ACC_LIMIT) ? acc * ACC_TEN + digit : ACC_SAT;
    wire       mnem_full = mnem[39:32] != 8'h00;
    wire [7:0] param    = (acc > 10'h0ff) ? 8'hff : acc[7:0];

    // Exact match only: a missing '?' or a typo matches nothing
    wire ok     = ~mnem_bad;                                  // see RQ17
    wire m_cls  = ok & (mnem == MN_CLS);
    wire m_ese  = ok & (mnem == MN_ESE) & have_param;
    wire m_eseq = ok & (mnem == MN_ESEQ);                     // see RQ16
    wire m_esrq = ok & (mnem == MN_ESRQ);
    wire m_idnq = ok & (mnem == MN_IDNQ);
    wire m_opc  = ok & (mnem == MN_OPC);
    wire m_opcq = ok & (mnem == MN_OPCQ);
    wire m_rst  = ok & (mnem == MN_RST);
    wire m_sre  = ok & (mnem == MN_SRE) & have_param;
    wire m_sreq = ok & (mnem == MN_SREQ);
    wire m_stbq = ok & (mnem == MN_STBQ);
    wire m_trg  = ok & (mnem == MN_TRG);
    wire m_tstq = ok & (mnem == MN_TSTQ);
    wire m_wai  = ok & (mnem == MN_WAI);

    wire exec_now  = take & is_sep;
    wire q_reply   = exec_now & (m_eseq | m_esrq | m_idnq | m_sreq | m_stbq | m_tstq);
    wire go_wait   = exec_now & (m_opcq | m_wai);             // see RQ19
    wire wait_done = (state == ST_WAIT) & ~ops_busy;
    wire start_reply = q_reply | (wait_done & m_opcq);        // see RQ8
    wire do_cls    = exec_now & m_cls;
    wire do_esrq   = exec_now & m_esrq;
    wire do_opc    = exec_now & m_opc;

    // Status byte and summaries
    wire       esb      = |(esr & ese);                        // see RQ20
    wire [7:0] stb_low  = {summary_in[7], 1'b0, esb, summary_in[4:0]};
    wire       mss      = |(stb_low & sre & MSS_MASK_OUT);     // see RQ11
    wire [7:0] stb      = stb_low | ({7'h00, mss} << BIT_MSS);

    // Event register: a new event wins over a same-cycle clear
    wire       opc_fire  = opc_pending & ~ops_busy;            // see RQ7
    wire [7:0] esr_set   = {event_in, opc_fire};
    wire       esr_clear = do_cls | do_esrq;                   // see RQ5
    wire [7:0] next_esr  = (esr_clear ? 8'h00 : esr) | esr_set;  // see RQ4

    // Reply framing
    wire [5:0] body_len = (reply_kind == RK_NUM) ? 6'd3 :
                          (reply_kind == RK_ONE) ? 6'd1 : 6'(ID_LEN);
    wire [5:0] term_len = (term_sel == TERM_NONE) ? 6'd0 :
                          (term_sel == TERM_LF)   ? 6'd1 : 6'd2;   // see RQ18
    wire [5:0] total    = body_len + term_len;
    wire       tx_valid = state == ST_REPLY;
    wire       pop      = rd_tx & tx_valid;
    wire       last     = reply_idx == total - 6'd1;
    wire       in_body  = reply_idx < body_len;
    wire       term_2nd = reply_idx != body_len;

    wire [7:0] hund_char;
    wire [7:0] tens_char;
    wire [7:0] ones_char;

    decimal_digits u_digits (
        .value     (reply_value),
        .hund_char (hund_char),
        .tens_char (tens_char),
        .ones_char (ones_char)
    );

    wire [7:0] num_char = (reply_idx == 6'd0) ? hund_char :
                          (reply_idx == 6'd1) ? tens_char : ones_char;
    // Out-of-range index shifts the text to zero; only used inside the body
    wire [7:0] idn_char = 8'(IDN_TEXT >> (8 * (ID_LEN - 1 - int'(reply_idx))));  // see RQ6
    wire [7:0] body_char = (reply_kind == RK_NUM) ? num_char :
                           (reply_kind == RK_ONE) ? reply_value : idn_char;
    wire [7:0] term_char = (term_sel == TERM_LFCR) ? (term_2nd ? CH_CR : CH_LF) :
                           (term_sel == TERM_LF)   ? CH_LF :
                           (term_2nd ? CH_LF : CH_CR);
    wire [7:0] tx_char  = in_body ? body_char : term_char;

    // Reply selection at query time
    assign next_kind  = m_idnq ? RK_IDN : (m_tstq | m_opcq) ? RK_ONE : RK_NUM;
    assign next_value = m_eseq ? ese :                         // see RQ3
                        m_esrq ? esr :
                        m_sreq ? sre :                         // see RQ12
                        m_stbq ? stb :                         // see RQ13
                        m_tstq ? (tst_result ? CH_ONE : CH_ZERO) :  // see RQ15
                        CH_ONE;                                // see RQ9

    // Parser
    always_comb begin
        next_state = state;
        next_mnem  = mnem;
        next_bad   = mnem_bad;
        next_acc   = acc;
        next_have  = have_param;
        if (exec_now) begin
            next_state = start_reply ? ST_REPLY : (go_wait ? ST_WAIT : ST_MNEM);
            if (!go_wait) begin
                next_mnem = 40'h0000000000;
                next_bad  = 1'b0;
                next_acc  = 10'h000;
                next_have = 1'b0;
            end
        end else begin
            unique case (state)
                ST_MNEM: begin
                    if (take && is_space) begin
                        if (mnem != 40'h0000000000) begin
                            next_state = ST_PARAM;
                        end
                    end else if (take && mnem_full) begin
                        next_bad = 1'b1;
                    end else if (take) begin
                        next_mnem = {mnem[31:0], rx_char};
                    end
                end
                ST_PARAM: begin
                    if (take && is_digit) begin
                        next_acc  = acc_step;
                        next_have = 1'b1;
                    end else if (take && !is_space) begin
                        next_bad = 1'b1;
                    end
                end
                ST_WAIT: begin
                    if (!ops_busy) begin
                        next_state = m_opcq ? ST_REPLY : ST_MNEM;
                        next_mnem  = 40'h0000000000;
                        next_bad   = 1'b0;
                        next_acc   = 10'h000;
                        next_have  = 1'b0;
                    end
                end
                ST_REPLY: begin
                    if (pop && last) begin
                        next_state = ST_MNEM;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= ST_MNEM;
            mnem       <= 40'h0000000000;
            mnem_bad   <= 1'b0;
            acc        <= 10'h000;
            have_param <= 1'b0;
        end else begin
            state      <= next_state;
            mnem       <= next_mnem;
            mnem_bad   <= next_bad;
            acc        <= next_acc;
            have_param <= next_have;
        end
    end

    // Status and enable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            esr         <= 8'h00;
            ese         <= 8'h00;
            sre         <= 8'h00;
            opc_pending <= 1'b0;
        end else begin
            esr <= next_esr;                                   // see RQ1
            if (exec_now && m_ese) begin
                ese <= param;                                  // see RQ2
            end
            if (exec_now && m_sre) begin
                sre <= param;                                  // see RQ11
            end
            if (do_cls) begin
                opc_pending <= 1'b0;                           // see RQ1
            end else if (do_opc) begin
                opc_pending <= 1'b1;                           // see RQ7
            end else if (opc_fire) begin
                opc_pending <= 1'b0;
            end
        end
    end

    // Reply position
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reply_kind  <= RK_NUM;
            reply_value <= 8'h00;
            reply_idx   <= 6'd0;
        end else if (start_reply) begin
            reply_kind  <= next_kind;
            reply_value <= next_value;
            reply_idx   <= 6'd0;
        end else if (pop) begin
            reply_idx <= last ? 6'd0 : reply_idx + 6'd1;
        end
    end

    // One-cycle strobes to the instrument core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_start  <= 1'b0;
            power_up_reset <= 1'b0;
            clear_pending  <= 1'b0;
        end else begin
            trigger_start  <= exec_now & m_trg;                // see RQ14
            power_up_reset <= exec_now & m_rst;                // see RQ10
            clear_pending  <= do_cls;                          // see RQ1
        end
    end

    // Self-test result caught once after reset release, then held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tst_taken  <= 1'b0;
            tst_result <= 1'b0;
        end else if (!tst_taken) begin
            tst_taken  <= 1'b1;
            tst_result <= selftest_fail;                       // see RQ15
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_sel <= TERM_RESET;
        end else if (wr_ctl) begin
            term_sel <= pwdata[1:0];                           // see RQ18
        end
    end

    // Read data is captured in the setup phase and stands through the access phase
    wire [31:0] read_mux = hit_tx  ? {23'h000000, tx_valid, tx_char} :
                           hit_st  ? {28'h0000000, state == ST_WAIT, opc_pending,
                                      tx_valid, rx_ready} :
                           hit_ctl ? {30'h00000000, term_sel} :
                           hit_stb ? {24'h000000, stb} :
                           hit_esr ? {24'h000000, esr} :
                           hit_en  ? {16'h0000, sre, ese} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup) begin
            prdata <= read_mux;
        end
    end

    assign service_request = mss;
endmodule

// ---- hdl/decimal_digits.sv ----
// Byte to three ASCII decimal digits
`timescale 1ns/1ps
module decimal_digits (
    input  wire logic [7:0] value,
    output logic      [7:0] hund_char,
    output logic      [7:0] tens_char,
    output logic      [7:0] ones_char
);
    import cmd_status_pkg::*;

    // Constant divisors only; synthesis folds these into small tables
    assign hund_char = CH_ZERO + value / 8'd100;
    assign tens_char = CH_ZERO + (value / 8'd10) % 8'd10;
    assign ones_char = CH_ZERO + value % 8'd10;
endmodule

// ---- testbench/cmd_status_properties.sv ----
// Port-level assertions for the common command and status unit
`timescale 1ns/1ps
module cmd_status_properties (
    input wire logic                              pclk,
    input wire logic                              presetn,
    input wire logic                              psel,
    input wire logic                              penable,
    input wire logic                              pwrite,
    input wire logic [cmd_status_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                       prdata,
    input wire logic                              pready,
    input wire logic                              pslverr,
    input wire logic                              service_request,
    input wire logic                              trigger_start,
    input wire logic                              power_up_reset,
    input wire logic                              clear_pending
);
    import cmd_status_pkg::*;
    wire acc = psel && penable;
    // Anything past the last word or off a word boundary is unmapped
    wire bad = (paddr > ADDR_ENABLES) || (paddr[1:0] != 2'h0);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy; acc |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no pready");
    property p_err; acc && bad |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("no slave error");
    property p_ok; acc && !bad |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("error on mapped word");
    property p_eacc; pslverr |-> psel && penable; endproperty
    a_eacc: assert property (p_eacc) else $error("error outside access");
    property p_zero; acc && !pwrite && (bad || paddr == ADDR_RX_DATA) |-> prdata == 32'h0; endproperty
    a_zero: assert property (p_zero) else $error("nonzero read");
    property p_trg; trigger_start |=> !trigger_start; endproperty
    a_trg: assert property (p_trg) else $error("trigger too long");
    property p_rst; $rose(power_up_reset) |=> $fell(power_up_reset); endproperty
    a_rst: assert property (p_rst) else $error("reset pulse too long");
    property p_clr; clear_pending |-> ##1 !clear_pending; endproperty
    a_clr: assert property (p_clr) else $error("clear pulse too long");
    c_trg: cover property (trigger_start);
    c_srq: cover property (service_request);
    c_bad: cover property (acc && bad);
endmodule

// ---- testbench/common_command_status_unit_test.sv ----
// Self-checking bench for the common command and status unit
`timescale 1ns/1ps
module common_command_status_unit_test;
    import cmd_status_pkg::*;
    logic         pclk = 0;
    logic         presetn = 0;
    logic         psel = 0;
    logic         penable = 0;
    logic         pwrite = 0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0;
    logic [7:1]   event_in = 7'h00;
    logic [7:0]   summary_in = 8'h00;
    logic         selftest_fail = 0;
    logic [31:0]  prdata, rd;
    logic         pready, pslverr, ops_busy, service_request, er;
    logic         trigger_start, power_up_reset, clear_pending;
    logic [319:0] rep;
    logic [7:0]   v, s;
    logic [1:0]   tc;
    int           mismatches = 0;
    int           samples_checked = 0;
    int           resets = 0;
    int           trigs = 0;
    always #20 pclk = ~pclk;
    common_command_status_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ops_busy(ops_busy),
        .event_in(event_in), .summary_in(summary_in), .selftest_fail(selftest_fail),
        .service_request(service_request), .trigger_start(trigger_start),
        .power_up_reset(power_up_reset), .clear_pending(clear_pending));
    core_model core (.pclk(pclk), .presetn(presetn), .trigger_start(trigger_start),
        .clear_pending(clear_pending), .ops_busy(ops_busy));
    always @(posedge pclk) begin
        if (power_up_reset === 1'b1) resets++;
        if (trigger_start === 1'b1) trigs++;
    end
    task check(input logic [319:0] seen, input logic [319:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Whole message then terminator, one character per write
    task send(input string c);
        foreach (c[i]) apb(1'b1, ADDR_RX_DATA, {24'h0, c[i]});
        apb(1'b1, ADDR_RX_DATA, {24'h0, CH_LF});
    endtask
    task reply;
        rep = '0;
        for (int i = 0; i < 40; i++) begin
            apb(1'b0, ADDR_TX_DATA, 32'h0);
            if (rd[8] !== 1'b1) break;
            rep = {rep[311:0], rd[7:0]};
        end
    endtask
    task settle;
        for (int i = 0; i < 100; i++) begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            if (rd[3] === 1'b0) break;
        end
    endtask
    function automatic logic [319:0] term(input logic [319:0] r, input logic [1:0] t);
        case (t)
            TERM_CRLF: return {r[303:0], CH_CR, CH_LF};
            TERM_LFCR: return {r[303:0], CH_LF, CH_CR};
            TERM_LF: return {r[311:0], CH_LF};
            default: return r;
        endcase
    endfunction
    function automatic logic [319:0] num(input logic [7:0] x, input logic [1:0] t);
        return term({296'h0, 8'h30 + x / 8'd100, 8'h30 + x / 8'd10 % 8'd10,
                     8'h30 + x % 8'd10}, t);
    endfunction
    task test_done;
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        mismatches++;
        test_done;
    end
    initial begin
        void'($urandom(56236));
        selftest_fail = 1'($urandom);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_CONTROL, 32'h0);
        check(rd[1:0], TERM_RESET);
        send("*TST?");
        reply;
        check(rep, term(selftest_fail ? "1" : "0", TERM_CRLF));
        for (int t = 0; t < 4; t++) begin
            tc = 2'(t);
            apb(1'b1, ADDR_CONTROL, {30'h0, tc});
            v = (t == 0) ? 8'hff : 8'($urandom);
            s = (t == 0) ? 8'h00 : 8'($urandom);
            send($sformatf("*ese %0d", v));
            send($sformatf("*SRE %0d", s));
            send("*ESE?");
            reply;
            check(rep, num(v, tc));
            send("*SRE?");
            reply;
            check(rep, num(s, tc));
        end
        apb(1'b1, ADDR_CONTROL, 32'h0);
        send("*ESX?");
        send("*ESE");
        send("*IDN");
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd[1], 1'b0);
        apb(1'b0, ADDR_ENABLES, 32'h0);
        check(rd[15:0], {s, v});
        send("*ESE 255");
        send("*SRE 32");
        summary_in <= 8'($urandom);
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            event_in <= (i % 2 == 0) ? 7'h04 : 7'h00;
        end
        apb(1'b0, ADDR_ESR, 32'h0);
        check(rd[7:0], 8'h08);
        apb(1'b0, ADDR_STB, 32'h0);
        check(rd[7:0], (summary_in & 8'h9f) | 8'h60);
        check(service_request, 1'b1);
        send("*STB?");
        reply;
        check(rep, num((summary_in & 8'h9f) | 8'h60, TERM_CRLF));
        apb(1'b0, ADDR_STB, 32'h0);
        check(rd[6], 1'b1);
        send("*ESR?");
        reply;
        check(rep, num(8'h08, TERM_CRLF));
        apb(1'b0, ADDR_ESR, 32'h0);
        check(rd[7:0], 8'h00);
        check(service_request, 1'b0);
        send("*TRG");
        send("*OPC");
        apb(1'b0, ADDR_ESR, 32'h0);
        check(rd[0], 1'b0);
        repeat (80) @(posedge pclk);
        apb(1'b0, ADDR_ESR, 32'h0);
        check(rd[0], 1'b1);
        send("*TRG");
        send("*OPC?");
        apb(1'b0, ADDR_STATUS, 32'h0);
        check({rd[3], rd[1]}, 2'b10);
        settle;
        reply;
        check(rep, term("1", TERM_CRLF));
        apb(1'b0, ADDR_ESR, 32'h0);
        check(rd[0], 1'b1);
        send("*TRG");
        send("*WAI");
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd[3], 1'b1);
        settle;
        check(rd[0], 1'b1);
        send("*TRG");
        send("*OPC");
        send("*CLS");
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd[2], 1'b0);
        apb(1'b0, ADDR_ESR, 32'h0);
        check(rd[7:0], 8'h00);
        check(trigs, 4);
        send("*RST");
        apb(1'b0, ADDR_ENABLES, 32'h0);
        check(rd[15:0], 16'h20ff);
        check(resets, 1);
        send("*IDN?");
        reply;
        check(rep, {"MFGR,MODEL-A,0000001,1.0/1.0", CH_CR, CH_LF});
        apb(1'b0, 8'h1c, 32'h0);
        check({er, rd}, 33'h100000000);
        test_done;
    end
endmodule
bind common_command_status_unit cmd_status_properties props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .service_request(service_request), .trigger_start(trigger_start),
    .power_up_reset(power_up_reset), .clear_pending(clear_pending));

// ---- testbench/core_model.sv ----
// Instrument core stand-in: one timed operation per trigger
`timescale 1ns/1ps
module core_model #(
    parameter int BUSY_LEN = 60
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic trigger_start,
    input  wire logic clear_pending,
    output logic      ops_busy
);
    int count;
    assign ops_busy = count != 0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 0;
        end else if (clear_pending) begin
            count <= 0;
        end else if (trigger_start) begin
            count <= BUSY_LEN;
        end else if (count != 0) begin
            count <= count - 1;
        end
    end
endmodule
